// File: isst_pkg.sv
// Purpose: constants and carrier types for the second status and scl timing block
// Assumes: 16-bit register data on a plain strobe port, byte addresses
// Notes: offsets of neighbouring registers are kept for reference only, not decoded
package isst_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS_ONE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OWN_ADDRESS_TWO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DATA_BYTE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS_ONE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS_TWO = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SCL_CLOCK_CONTROL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MAX_RISE_TIME = 8'h20;
  localparam logic [DATA_W-1:0] RST_STATUS_TWO = 16'h0000;
  localparam logic [DATA_W-1:0] RST_SCL_CLOCK_CONTROL = 16'h0000;
  localparam logic [5:0] RST_MAX_RISE_TIME = 6'h02;
  // field positions
  localparam int POS_SPEED = 15;
  localparam int POS_DUTY = 14;
  localparam int POS_CODE_LO = 8;
  localparam int POS_DUAL = 7;
  localparam int POS_HOST = 6;
  localparam int POS_DEFAULT = 5;
  localparam int POS_GEN_CALL = 4;
  localparam int POS_DIR = 2;
  localparam int POS_BUSY = 1;
  localparam int POS_MASTER = 0;
  localparam int PERIOD_W = 12;
  localparam int RISE_W = 6;
  localparam int CNT_W = 17;
  // period multipliers per mode
  localparam logic [4:0] MUL_ONE = 5'h01;
  localparam logic [4:0] MUL_TWO = 5'h02;
  localparam logic [4:0] MUL_NINE = 5'h09;
  localparam logic [4:0] MUL_SIXTEEN = 5'h10;

  typedef enum logic [2:0] {
    SCL_IDLE = 3'b001,
    SCL_LOW = 3'b010,
    SCL_HIGH = 3'b100
  } isst_scl_state_type;

  // address match event from the address comparator
  typedef struct packed {
    logic hit;
    logic second_addr;
    logic general_call;
    logic dflt;
    logic host;
  } isst_match_type;

  // configuration bits held in the control registers elsewhere
  typedef struct packed {
    logic peripheral_enable;
    logic packet_check_enable;
    logic host_type_select;
    logic address_resolution_enable;
    logic general_call_enable;
  } isst_cfg_type;
endpackage

// File: isst_top.sv
// Purpose: second status register, bus busy tracking and master scl period generation
// Assumes: scl and sda pins are asynchronous; other inputs come from logic on ref_clk
// Notes: scl is open drain, the pin is pulled low only while oe_r is high
`timescale 1ns/10ps
module isst_top
  import isst_pkg::*;
#(
  parameter int PERIOD_BITS = PERIOD_W,
  parameter int RISE_BITS = RISE_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire isst_cfg_type cfg,
  input wire isst_match_type match_evt,
  input wire logic addr_phase_done,
  input wire logic addr_rw_bit,
  input wire logic start_generated,
  input wire logic arbitration_lost,
  input wire logic first_status_read,
  input wire logic [7:0] packet_error_code,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic addr_flag_clear,
  output logic stop_detected_flag,
  output logic bus_busy
);

  if (PERIOD_BITS != PERIOD_W || RISE_BITS != RISE_W) begin : g_bad_width
    $error("isst_top: field widths are fixed by the register layout");
  end

  // reset release
  logic rst_meta_r, rst_n_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // pin synchronisers; first stage read only by the second
  logic [1:0] scl_meta_r, sda_meta_r;
  logic scl_s_r, sda_s_r, scl_d_r, sda_d_r;
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_meta_r <= {scl_meta_r[0], scl_in};
      sda_meta_r <= {sda_meta_r[0], sda_in};
      scl_s_r <= scl_meta_r[1];
      sda_s_r <= sda_meta_r[1];
      scl_d_r <= scl_s_r;
      sda_d_r <= sda_s_r;
    end
  end

  logic stop_seen, start_seen;
  assign stop_seen = scl_s_r && scl_d_r && sda_s_r && !sda_d_r;
  assign start_seen = scl_s_r && scl_d_r && !sda_s_r && sda_d_r;

  // status flags
  logic dual_r, host_r, dflt_r, gen_call_r, dir_r, busy_r, master_r, restart_r;
  logic dual_nxt, host_nxt, dflt_nxt, gen_call_nxt, dir_nxt, busy_nxt, master_nxt;
  logic sr1_seen_r, sr1_seen_nxt, addr_clr_r, addr_clr_nxt, stop_r, stop_nxt;
  logic flag_clr, enabled, sr2_read;
  assign enabled = cfg.peripheral_enable;
  assign sr2_read = reg_rd && reg_addr == OFS_STATUS_TWO;
  // a start seen while the bus is already busy is a repeated start
  assign flag_clr = stop_seen || (start_seen && busy_r);

  always_comb begin
    dual_nxt = dual_r;
    host_nxt = host_r;
    dflt_nxt = dflt_r;
    gen_call_nxt = gen_call_r;
    if (flag_clr) begin
      dual_nxt = 1'b0;
      host_nxt = 1'b0;
      dflt_nxt = 1'b0;
      gen_call_nxt = 1'b0;
    end
    if (match_evt.hit) begin
      dual_nxt = match_evt.second_addr;
      host_nxt = match_evt.host && cfg.host_type_select && cfg.address_resolution_enable;
      dflt_nxt = match_evt.dflt && cfg.address_resolution_enable;
      gen_call_nxt = match_evt.general_call && cfg.general_call_enable;
    end
    if (!enabled) begin
      dual_nxt = 1'b0;
      host_nxt = 1'b0;
      dflt_nxt = 1'b0;
      gen_call_nxt = 1'b0;
    end
    dir_nxt = dir_r;
    if (stop_seen || (start_seen && busy_r) || arbitration_lost) begin
      dir_nxt = 1'b0;
    end
    if (addr_phase_done) begin
      dir_nxt = addr_rw_bit;
    end
    if (!enabled) begin
      dir_nxt = 1'b0;
    end
    // busy ignores the enable on purpose
    busy_nxt = busy_r;
    if (!scl_s_r || !sda_s_r) begin
      busy_nxt = 1'b1;
    end else if (stop_seen) begin
      busy_nxt = 1'b0;
    end
    master_nxt = master_r;
    if (stop_seen || arbitration_lost) begin
      master_nxt = 1'b0;
    end else if (start_generated) begin
      master_nxt = 1'b1;
    end
    if (!enabled) begin
      master_nxt = 1'b0;
    end
    sr1_seen_nxt = sr1_seen_r;
    addr_clr_nxt = 1'b0;
    if (sr2_read) begin
      addr_clr_nxt = sr1_seen_r;
      sr1_seen_nxt = 1'b0;
    end
    if (first_status_read) begin
      sr1_seen_nxt = 1'b1;
    end
    stop_nxt = stop_seen;
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dual_r <= 1'b0;
      host_r <= 1'b0;
      dflt_r <= 1'b0;
      gen_call_r <= 1'b0;
      dir_r <= 1'b0;
      busy_r <= 1'b0;
      master_r <= 1'b0;
      sr1_seen_r <= 1'b0;
      addr_clr_r <= 1'b0;
      stop_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      dual_r <= dual_nxt;
      host_r <= host_nxt;
      dflt_r <= dflt_nxt;
      gen_call_r <= gen_call_nxt;
      dir_r <= dir_nxt;
      busy_r <= busy_nxt;
      master_r <= master_nxt;
      sr1_seen_r <= sr1_seen_nxt;
      addr_clr_r <= addr_clr_nxt;
      stop_r <= stop_nxt;
      restart_r <= start_seen && busy_r;
    end
  end

  // clock control and rise time registers
  logic speed_r, duty_r, speed_nxt, duty_nxt;
  logic [PERIOD_W-1:0] period_r, period_nxt;
  logic [RISE_W-1:0] rise_r, rise_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [7:0] code_view;
  assign code_view = cfg.packet_check_enable ? packet_error_code : 8'h00;

  always_comb begin
    speed_nxt = speed_r;
    duty_nxt = duty_r;
    period_nxt = period_r;
    rise_nxt = rise_r;
    if (reg_wr && reg_addr == OFS_SCL_CLOCK_CONTROL) begin
      speed_nxt = reg_wdata[POS_SPEED];
      duty_nxt = reg_wdata[POS_DUTY];
      period_nxt = reg_wdata[PERIOD_W-1:0];
    end
    if (reg_wr && reg_addr == OFS_MAX_RISE_TIME) begin
      rise_nxt = reg_wdata[RISE_W-1:0];
    end
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS_TWO: begin
          rdata_nxt = {code_view, dual_r, host_r, dflt_r, gen_call_r, 1'b0, dir_r, busy_r, master_r};
        end
        OFS_SCL_CLOCK_CONTROL: begin
          rdata_nxt = {speed_r, duty_r, 2'h0, period_r};
        end
        OFS_MAX_RISE_TIME: begin
          rdata_nxt = {10'h000, rise_r};
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      speed_r <= RST_SCL_CLOCK_CONTROL[POS_SPEED];
      duty_r <= RST_SCL_CLOCK_CONTROL[POS_DUTY];
      period_r <= RST_SCL_CLOCK_CONTROL[PERIOD_W-1:0];
      rise_r <= RST_MAX_RISE_TIME;
      rdata_r <= 16'h0000;
    end else begin
      speed_r <= speed_nxt;
      duty_r <= duty_nxt;
      period_r <= period_nxt;
      rise_r <= rise_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // scl period generator, counts in ref_clk cycles
  logic [4:0] mul_high, mul_low;
  logic [CNT_W-1:0] high_len, low_len;
  always_comb begin
    if (!speed_r) begin
      mul_high = MUL_ONE;
      mul_low = MUL_ONE;
    end else if (!duty_r) begin
      mul_high = MUL_ONE;
      mul_low = MUL_TWO;
    end else begin
      mul_high = MUL_NINE;
      mul_low = MUL_SIXTEEN;
    end
    high_len = CNT_W'(period_r) * CNT_W'(mul_high);
    low_len = CNT_W'(period_r) * CNT_W'(mul_low);
  end

  isst_scl_state_type scl_st_r, scl_st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic oe_r, oe_nxt;
  logic [CNT_W-1:0] low_run_r, low_run_nxt;
  logic gen_run;
  assign gen_run = enabled && master_r;

  always_comb begin
    scl_st_nxt = scl_st_r;
    cnt_nxt = cnt_r;
    oe_nxt = oe_r;
    low_run_nxt = oe_r ? CNT_W'(low_run_r + 1'b1) : '0;
    case (scl_st_r)
      SCL_IDLE: begin
        oe_nxt = 1'b0;
        cnt_nxt = '0;
        if (gen_run) begin
          scl_st_nxt = SCL_HIGH;
        end
      end
      SCL_LOW: begin
        oe_nxt = 1'b1;
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r + 1'b1 >= low_len) begin
          scl_st_nxt = SCL_HIGH;
          oe_nxt = 1'b0;
          cnt_nxt = '0;
        end
      end
      SCL_HIGH: begin
        oe_nxt = 1'b0;
        // the rise allowance is counted into the high time; past it a low line is a stretch
        if (scl_s_r || cnt_r < CNT_W'(rise_r)) begin
          cnt_nxt = cnt_r + 1'b1;
        end
        if (cnt_r + 1'b1 >= high_len && scl_s_r) begin
          scl_st_nxt = SCL_LOW;
          oe_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      default: begin
        scl_st_nxt = SCL_IDLE;
        oe_nxt = 1'b0;
        cnt_nxt = '0;
      end
    endcase
    if (!gen_run) begin
      scl_st_nxt = SCL_IDLE;
      oe_nxt = 1'b0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_st_r <= SCL_IDLE;
      cnt_r <= '0;
      oe_r <= 1'b0;
      low_run_r <= '0;
    end else begin
      scl_st_r <= scl_st_nxt;
      cnt_r <= cnt_nxt;
      oe_r <= oe_nxt;
      low_run_r <= low_run_nxt;
    end
  end

  logic scl_zero_r;
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_zero_r <= 1'b0;
    end else begin
      scl_zero_r <= 1'b0;
    end
  end

  assign reg_rdata = rdata_r;
  assign scl_out = scl_zero_r;
  assign scl_oe = oe_r;
  assign addr_flag_clear = addr_clr_r;
  assign stop_detected_flag = stop_r;
  assign bus_busy = busy_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  a_addr_clear_pair: assert property ((reg_rd && reg_addr == OFS_STATUS_TWO && sr1_seen_r) |=> addr_flag_clear)
    else $error("address clear missing after status pair read");
  a_dir_from_rw: assert property ((addr_phase_done && enabled) |=> dir_r == $past(addr_rw_bit))
    else $error("direction flag not taken from rw bit");
  a_dir_cleared: assert property ((enabled && !addr_phase_done && (stop_seen || arbitration_lost)) |=> !dir_r)
    else $error("direction flag survived stop or loss");
  a_busy_on_low: assert property ((!scl_s_r || !sda_s_r) |=> busy_r)
    else $error("busy not set on low line");
  a_busy_stop_clear: assert property ((stop_seen && scl_s_r && sda_s_r) |=> !busy_r)
    else $error("busy not cleared by stop");
  a_master_set: assert property ((enabled && start_generated && !stop_seen && !arbitration_lost) |=> master_r)
    else $error("master flag not set after start");
  a_flags_disable: assert property (!enabled |=> !(dual_r || host_r || dflt_r || gen_call_r || master_r || dir_r))
    else $error("flags held while disabled");
  a_general_call_gate: assert property ((enabled && match_evt.hit) |=>
    gen_call_r == $past(match_evt.general_call && cfg.general_call_enable))
    else $error("general call flag gating wrong");
  // low phase measured on the pin enable itself, against the mode multiplier
  a_low_len: assert property ((oe_r && !oe_nxt && gen_run && period_r != '0) |->
    int'(low_run_r) + 1 == int'(period_r) * (!speed_r ? int'(MUL_ONE) : (duty_r ? int'(MUL_SIXTEEN) : int'(MUL_TWO))))
    else $error("scl low phase length wrong");
  a_read_cfg: assert property ((reg_rd && reg_addr == OFS_SCL_CLOCK_CONTROL) |=> reg_rdata[13:12] == 2'h0)
    else $error("reserved clock bits read nonzero");
  a_code_byte: assert property ((reg_rd && reg_addr == OFS_STATUS_TWO) |=>
    reg_rdata[15:8] == $past(cfg.packet_check_enable ? packet_error_code : 8'h00))
    else $error("packet code byte wrong");

  c_addr_pair: cover property (first_status_read ##[1:20] (reg_rd && reg_addr == OFS_STATUS_TWO));
  c_master_run: cover property (master_r && scl_st_r == SCL_LOW ##[1:200] scl_st_r == SCL_HIGH);
  c_busy_cycle: cover property (busy_r ##[1:500] !busy_r);
  c_restart: cover property (restart_r);
endmodule

// File: isst_bus_model.sv
// Purpose: far-side device sharing the open-drain scl and sda lines
// Assumes: pull-ups on both lines, 800 ns link period, times in ns
// Notes: lines stand still between frames; the scl wire is and-ed with the block's pull-down
`timescale 1ns/10ps
module isst_bus_model (
  input wire logic scl_oe,
  output logic scl_line,
  output logic sda_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // a released line reads high through its pull-up, never a stale value
  assign scl_line = !(scl_oe || scl_low);
  assign sda_line = !sda_low;
  // sda falls while scl is high; works from idle and as a repeated start
  task automatic start_cond();
    sda_low = 1'b0;
    #200;
    scl_low = 1'b0;
    #200;
    sda_low = 1'b1;
    #400;
    scl_low = 1'b1;
    #400;
  endtask
  // sda rises while scl is high
  task automatic stop_cond();
    scl_low = 1'b1;
    sda_low = 1'b1;
    #400;
    scl_low = 1'b0;
    #400;
    sda_low = 1'b0;
    #400;
  endtask
  // slow device: stretches the clock low
  task automatic hold_scl(input int ns);
    scl_low = 1'b1;
    #(ns);
    scl_low = 1'b0;
  endtask
endmodule

// File: testbench.sv
// Purpose: self-checking bench for the second status and scl timing block
// Assumes: bus model drives the pins, ref_clk at 100 ns
// Notes: scl periods are measured on scl_oe in ref_clk cycles
`timescale 1ns/10ps
module testbench import isst_pkg::*;;
  localparam int EV_START = 0;
  localparam int EV_LOSS = 1;
  localparam int EV_ADDR = 2;
  localparam int EV_SR1 = 3;
  localparam int EV_HIT = 4;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  isst_cfg_type cfg = '0;
  isst_match_type match_evt = '0;
  logic addr_phase_done = 1'b0;
  logic addr_rw_bit = 1'b0;
  logic start_generated = 1'b0;
  logic arbitration_lost = 1'b0;
  logic first_status_read = 1'b0;
  logic [7:0] packet_error_code = 8'hA5;
  logic [DATA_W-1:0] reg_rdata;
  logic scl_line, sda_line, scl_out, scl_oe, addr_flag_clear, stop_detected_flag, bus_busy;
  logic [15:0] rdat;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int stops = 0;

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  isst_top u_isst_top (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg(cfg), .match_evt(match_evt),
    .addr_phase_done(addr_phase_done), .addr_rw_bit(addr_rw_bit), .start_generated(start_generated),
    .arbitration_lost(arbitration_lost), .first_status_read(first_status_read),
    .packet_error_code(packet_error_code), .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .addr_flag_clear(addr_flag_clear), .stop_detected_flag(stop_detected_flag),
    .bus_busy(bus_busy));
  isst_bus_model u_isst_bus_model (.scl_oe(scl_oe), .scl_line(scl_line), .sda_line(sda_line));

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (stop_detected_flag === 1'b1) begin
      stops <= stops + 1;
    end
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rdat = reg_rdata;
  endtask

  task automatic pulse(input int sel);
    @(posedge ref_clk);
    case (sel)
      EV_START: start_generated <= 1'b1;
      EV_LOSS: arbitration_lost <= 1'b1;
      EV_ADDR: addr_phase_done <= 1'b1;
      EV_SR1: first_status_read <= 1'b1;
      default: match_evt.hit <= 1'b1;
    endcase
    @(posedge ref_clk);
    {start_generated, arbitration_lost, addr_phase_done, first_status_read, match_evt.hit} <= 5'h00;
  endtask

  // kind is {dual, host header, default address, general call}
  function automatic logic [15:0] sr2(input logic [7:0] code, input logic [3:0] kind, input logic [2:0] low);
    return {code, kind, 1'b0, low};
  endfunction

  task automatic t_regs();
    rd(OFS_STATUS_TWO);
    chk(rdat, 16'h0000);
    rd(OFS_SCL_CLOCK_CONTROL);
    chk(rdat, 16'h0000);
    rd(OFS_MAX_RISE_TIME);
    chk(rdat, 16'h0002);
    wr(OFS_SCL_CLOCK_CONTROL, 16'hFFFF);
    wr(OFS_MAX_RISE_TIME, 16'hFFFF);
    wr(OFS_STATUS_TWO, 16'hFFFF);
    wr(OFS_CONTROL_ONE, 16'hFFFF);
    rd(OFS_SCL_CLOCK_CONTROL);
    chk(rdat, 16'hCFFF);
    rd(OFS_MAX_RISE_TIME);
    chk(rdat, 16'h003F);
    rd(OFS_STATUS_TWO);
    chk(rdat, 16'h0000);
    rd(OFS_CONTROL_ONE);
    chk(rdat, 16'h0000);
    wr(OFS_SCL_CLOCK_CONTROL, 16'h0000);
    wr(OFS_MAX_RISE_TIME, 16'h0002);
  endtask

  task automatic t_flags();
    logic [4:0] cf [4] = '{5'h10, 5'h12, 5'h16, 5'h17};
    logic [3:0] ek [4] = '{4'h0, 4'h2, 4'h6, 4'h7};
    cfg <= 5'h1F;
    match_evt <= 5'h0F;
    addr_rw_bit <= 1'b1;
    pulse(EV_HIT);
    pulse(EV_ADDR);
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'hA5, 4'hF, 3'b100));
    pulse(EV_LOSS);
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'hA5, 4'hF, 3'b000));
    cfg.packet_check_enable <= 1'b0;
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'h00, 4'hF, 3'b000));
    cfg <= 5'h00;
    rd(OFS_STATUS_TWO);
    chk(rdat, 16'h0000);
    match_evt <= 5'h07;
    for (int i = 0; i < 4; i++) begin
      cfg <= cf[i];
      pulse(EV_HIT);
      rd(OFS_STATUS_TWO);
      chk(rdat, sr2(8'h00, ek[i], 3'b000));
    end
    cfg <= 5'h00;
  endtask

  task automatic t_addr_clear();
    pulse(EV_SR1);
    rd(OFS_SCL_CLOCK_CONTROL);
    chk({15'h0, addr_flag_clear}, 16'h0000);
    rd(OFS_STATUS_TWO);
    chk({15'h0, addr_flag_clear}, 16'h0001);
    rd(OFS_STATUS_TWO);
    chk({15'h0, addr_flag_clear}, 16'h0000);
  endtask

  task automatic t_bus();
    int s0;
    s0 = stops;
    tick(2);
    chk({15'h0, bus_busy}, 16'h0000);
    chk({15'h0, scl_out}, 16'h0000);
    u_isst_bus_model.start_cond();
    tick(4);
    chk({15'h0, bus_busy}, 16'h0001);
    u_isst_bus_model.stop_cond();
    tick(4);
    chk({15'h0, bus_busy}, 16'h0000);
    chk(16'(stops - s0), 16'h0001);
    cfg <= 5'h1F;
    u_isst_bus_model.start_cond();
    match_evt <= 5'h0F;
    pulse(EV_HIT);
    pulse(EV_ADDR);
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'hA5, 4'hF, 3'b110));
    u_isst_bus_model.start_cond();
    tick(4);
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'hA5, 4'h0, 3'b010));
    pulse(EV_HIT);
    pulse(EV_ADDR);
    u_isst_bus_model.stop_cond();
    tick(4);
    rd(OFS_STATUS_TWO);
    chk(rdat, sr2(8'hA5, 4'h0, 3'b000));
    cfg <= 5'h00;
  endtask

  task automatic t_scl(input logic fs, input logic duty, input logic [11:0] p, input int lo,
                       input int mn, input int mx, input int st);
    int n;
    wr(OFS_SCL_CLOCK_CONTROL, {fs, duty, 2'b00, p});
    wr(OFS_MAX_RISE_TIME, 16'h0002);
    cfg <= 5'h10;
    pulse(EV_START);
    rd(OFS_STATUS_TWO);
    chk(rdat & 16'h0001, 16'h0001);
    n = 0;
    while (scl_oe !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    n = 0;
    while (scl_oe === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(lo));
    if (st > 0) begin
      fork
        u_isst_bus_model.hold_scl(st);
      join_none
    end
    n = 0;
    while (scl_oe !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(16'(n >= mn && n <= mx), 16'h0001);
    pulse(EV_LOSS);
    tick(1);
    chk({15'h0, scl_oe}, 16'h0000);
    rd(OFS_STATUS_TWO);
    chk(rdat & 16'h0001, 16'h0000);
    cfg <= 5'h00;
    tick(1);
    u_isst_bus_model.stop_cond();
    tick(4);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_flags();
    t_addr_clear();
    t_bus();
    t_scl(1'b0, 1'b0, 12'h004, 4, 4, 10, 0);
    t_scl(1'b1, 1'b0, 12'h004, 8, 4, 10, 0);
    t_scl(1'b1, 1'b1, 12'h001, 16, 9, 15, 0);
    t_scl(1'b0, 1'b0, 12'h004, 4, 20, 32, 2000);
    final_report();
  end
endmodule
